// ---- src/eq_ctrl_pkg.sv ----
package eq_ctrl_pkg;
    // word layout, least significant bit shifted first
    localparam int WORD_W = 8;
    localparam int TYPE_BIT = 7;
    localparam int RANGE_A_BIT = 4;
    localparam int RANGE_B_BIT = 5;
    localparam int BAND_LSB = 0;
    localparam int BAND_W = 4;
    localparam int BOOST_BIT = 6;
    localparam int GAIN_LSB = 0;
    localparam int GAIN_W = 6;
    localparam int NUM_BANDS = 14;
    localparam int BANDS_PER_CH = 7;
    localparam int GAIN_STEPS = 12;
    localparam int SW_PER_BAND = 12;

    // apb register byte offsets
    localparam logic [11:0] OFS_STATUS = 12'h000;
    localparam logic [11:0] OFS_BAND = 12'h004;
    localparam logic [11:0] OFS_GAIN_BASE = 12'h040;
    localparam logic [11:0] OFS_SHIFT = 12'h008;

    // reset values
    localparam logic [WORD_W-1:0] BAND_RST = 8'h80;
    localparam logic [WORD_W-1:0] GAIN_RST = 8'h00;

    // gain code field decode
    typedef struct packed {
        logic is_band;
        logic boost;
        logic [GAIN_W-1:0] code;
    } ctrl_word_t;

    typedef struct packed {
        logic [3:0] band;
        logic range_a_narrow;
        logic range_b_narrow;
    } band_sel_t;

    typedef struct packed {
        logic boost;
        logic [3:0] steps;
    } band_gain_t;
endpackage

// ---- src/eq_gain_decoder.sv ----
`timescale 1ns/1ps
module eq_gain_decoder
    import eq_ctrl_pkg::*;
(
    input wire logic [WORD_W-1:0] word,
    input wire logic narrow,
    output band_gain_t gain,
    output logic [SW_PER_BAND-1:0] switches
);
    // code table: twelve listed codes, one per 1 dB step, flat otherwise
    function automatic logic [3:0] steps_of(input logic [GAIN_W-1:0] c);
        unique case (c)
            6'h20: steps_of = 4'd1;
            6'h10: steps_of = 4'd2;
            6'h08: steps_of = 4'd3;
            6'h04: steps_of = 4'd4;
            6'h02: steps_of = 4'd5;
            6'h12: steps_of = 4'd6;
            6'h2a: steps_of = 4'd7;
            6'h16: steps_of = 4'd8;
            6'h01: steps_of = 4'd9;
            6'h29: steps_of = 4'd10;
            6'h2d: steps_of = 4'd11;
            6'h2f: steps_of = 4'd12;
            default: steps_of = 4'd0;
        endcase
    endfunction

    logic [3:0] st;

    // boost/cut flag chooses sign, code chooses magnitude
    always_comb
    begin
        st = steps_of(word[GAIN_LSB +: GAIN_W]);
        gain.boost = word[BOOST_BIT];
        gain.steps = st;
        switches = '0;
        // flat leaves every switch of the band open
        if (st != 4'd0)
        begin
            // boost switches low half, cut high half; narrow leaves them unchanged
            if (word[BOOST_BIT])
                switches[5:0] = word[GAIN_LSB +: GAIN_W];
            else
                switches[11:6] = word[GAIN_LSB +: GAIN_W];
            if (narrow)
                switches = switches & {SW_PER_BAND{1'b1}};
        end
    end
endmodule

// ---- src/equalizer_serial_control.sv ----
`timescale 1ns/1ps
module equalizer_serial_control
    import eq_ctrl_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic serial_clk,
    input wire logic serial_data,
    input wire logic latch_pulse_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic [NUM_BANDS*SW_PER_BAND-1:0] band_switches,
    output logic range_a_narrow,
    output logic range_b_narrow
);
    // the logic below assumes an eight-bit word split into two halves
    if (WORD_W != 8)
    begin : g_chk_word
        $error("control word must be eight bits wide");
    end

    // one band code per band, two channels of equal size
    if (NUM_BANDS != 2 * BANDS_PER_CH)
    begin : g_chk_bands
        $error("band count must cover two equal channels");
    end

    // a band owns one boost half and one cut half of its switches
    if (SW_PER_BAND != 2 * GAIN_W)
    begin : g_chk_switches
        $error("switch count must be twice the gain code width");
    end

    // band field must sit below the type and range bits
    if (BAND_LSB + BAND_W > RANGE_A_BIT)
    begin : g_chk_band_field
        $error("band field overlaps the range bits");
    end

    // gain code must sit below the boost/cut flag
    if (GAIN_LSB + GAIN_W > BOOST_BIT)
    begin : g_chk_gain_field
        $error("gain field overlaps the boost flag");
    end

    // a four-bit band code can only name fourteen bands
    if (NUM_BANDS > 14)
    begin : g_chk_band_code
        $error("band code cannot address that many bands");
    end

    // two-flop synchronisers for the three pins
    logic [2:0] sync1_q;
    logic [2:0] sync2_q;
    logic [2:0] prev_q;
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            // idle levels: latch high, clock low, so no false edge
            sync1_q <= 3'h4;
            sync2_q <= 3'h4;
            prev_q <= 3'h4;
        end
        else
        begin
            sync1_q <= {latch_pulse_n, serial_data, serial_clk};
            sync2_q <= sync1_q;
            prev_q <= sync2_q;
        end
    end

    logic clk_rise;
    logic latch_rise;
    logic latch_low;
    assign clk_rise = sync2_q[0] & ~prev_q[0];
    assign latch_rise = sync2_q[2] & ~prev_q[2];
    assign latch_low = ~sync2_q[2];

    // shift register; newest bit enters at top, so bit 0 ends at lsb
    logic [WORD_W-1:0] shift_q;
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            shift_q <= '0;
        else if (clk_rise && !latch_low) // host idles during latch
            shift_q <= {sync2_q[1], shift_q[WORD_W-1:1]};
    end

    // holding registers; band word stays until replaced
    logic [WORD_W-1:0] band_q;
    logic [WORD_W-1:0] gain_q [NUM_BANDS];
    logic [3:0] band_code;
    assign band_code = band_q[BAND_LSB +: BAND_W];

    // decoding shared by the gain store and the drop counter
    function automatic logic band_valid(input logic [3:0] code);
        band_valid = (code != 4'h0) && (code != 4'hf);
    endfunction

    // saturating increment: status counters must not wrap to zero
    function automatic logic [3:0] sat_inc(input logic [3:0] v);
        if (v == 4'hf)
            sat_inc = v;
        else
            sat_inc = v + 4'h1;
    endfunction

    // latch completes on rising edge after low phase
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            band_q <= BAND_RST;
        else if (latch_rise && shift_q[TYPE_BIT]) // band word
            band_q <= shift_q;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            for (int i = 0; i < NUM_BANDS; i++)
                gain_q[i] <= GAIN_RST;
        end
        else if (latch_rise && !shift_q[TYPE_BIT]) // gain word
        begin
            // codes 0 and 15 select no band, so the word is dropped
            if (band_valid(band_code))
                gain_q[band_code - 4'h1] <= shift_q;
        end
    end

    // frame tracker, so software can see where the host stands
    typedef enum logic [1:0] {FR_IDLE, FR_SHIFT, FR_LATCH} frame_t;
    frame_t frame_q;
    frame_t frame_d;
    always_comb
    begin
        frame_d = frame_q;
        unique case (frame_q)
            FR_IDLE:
                if (latch_low)
                    frame_d = FR_LATCH;
                else if (clk_rise)
                    frame_d = FR_SHIFT;
            FR_SHIFT:
                if (latch_low)
                    frame_d = FR_LATCH;
            FR_LATCH:
                if (latch_rise)
                    frame_d = FR_IDLE;
            // two-bit code has one unused value
            default:
                frame_d = FR_IDLE;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            frame_q <= FR_IDLE;
        else
            frame_q <= frame_d;
    end

    // bits shifted since the last latch; saturates on long frames
    logic [3:0] bits_q;
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            bits_q <= 4'h0;
        else if (latch_rise)
            bits_q <= 4'h0;
        else if (clk_rise && !latch_low)
            bits_q <= sat_inc(bits_q);
    end

    // last frame had exactly one word; extra bits are legal but lossy
    logic frame_ok_q;
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            frame_ok_q <= 1'b0;
        else if (latch_rise)
            frame_ok_q <= (bits_q == 4'(WORD_W));
    end

    // type of the last latched word, high for a band word
    logic last_band_q;
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            last_band_q <= 1'b0;
        else if (latch_rise)
            last_band_q <= shift_q[TYPE_BIT];
    end

    // gain words thrown away because no band was selected
    logic [3:0] drop_q;
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            drop_q <= 4'h0;
        else if (latch_rise && !shift_q[TYPE_BIT] &&
                 !band_valid(band_code))
            drop_q <= sat_inc(drop_q);
    end

    // status view; pin levels stay in the low three bits
    logic [31:0] status;
    assign status = {14'h0, drop_q, 2'h0, frame_q, bits_q, frame_ok_q,
                     last_band_q, 1'b0, sync2_q};

    assign range_a_narrow = band_q[RANGE_A_BIT];
    assign range_b_narrow = band_q[RANGE_B_BIT];

    // per-band switch decode; channel a bands 1..7, b bands 8..14
    logic [SW_PER_BAND-1:0] sw_d [NUM_BANDS];
    for (genvar g = 0; g < NUM_BANDS; g++)
    begin : g_band
        eq_gain_decoder u_dec (
            .word(gain_q[g]),
            .narrow(g < BANDS_PER_CH ? band_q[RANGE_A_BIT]
                                     : band_q[RANGE_B_BIT]),
            .gain(),
            .switches(sw_d[g])
        );
    end

    // registered switch outputs follow holding registers
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            band_switches <= '0;
        else
            for (int i = 0; i < NUM_BANDS; i++)
                band_switches[i*SW_PER_BAND +: SW_PER_BAND] <= sw_d[i];
    end

    // apb: zero wait states, read-only status, band, shift and gain views
    logic [3:0] gidx;
    logic in_gain;
    assign gidx = paddr[5:2];
    assign in_gain = (paddr >= OFS_GAIN_BASE) &&
                     (paddr < OFS_GAIN_BASE + 12'h038) &&
                     (paddr[1:0] == 2'b00);
    assign pready = 1'b1;
    logic hit;
    always_comb
    begin
        hit = (paddr == OFS_STATUS) || (paddr == OFS_BAND) ||
              (paddr == OFS_SHIFT) || in_gain;
        pslverr = psel & penable & (~hit | pwrite);
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            prdata <= '0;
        else if (psel && !penable && !pwrite)
        begin
            prdata <= '0;
            if (paddr == OFS_STATUS)
                prdata <= status;
            else if (paddr == OFS_BAND)
                prdata <= {24'h0, band_q};
            else if (paddr == OFS_SHIFT)
                prdata <= {24'h0, shift_q};
            else if (in_gain)
                prdata <= {24'h0, gain_q[gidx]};
        end
    end
endmodule

// ---- verif/eq_word_gen.sv ----
`timescale 1ns/1ps
module eq_word_gen (
    input wire logic pclk,
    output logic serial_clk,
    output logic serial_data,
    output logic latch_pulse_n
);
    initial
    begin
        serial_clk = 1'b0;
        serial_data = 1'b0;
        latch_pulse_n = 1'b1;
    end
    // eight bits lsb first, clock parked low between frames
    task automatic send(input logic [7:0] w);
        for (int i = 0; i < 8; i++)
        begin
            serial_data <= w[i];
            repeat (4) @(posedge pclk);
            serial_clk <= 1'b1;
            repeat (4) @(posedge pclk);
            serial_clk <= 1'b0;
        end
        serial_data <= ~w[7]; // released: never leave a stale bit
        repeat (4) @(posedge pclk);
        latch_pulse_n <= 1'b0; // clock and data quiet
        repeat (4) @(posedge pclk);
        latch_pulse_n <= 1'b1;
        repeat (8) @(posedge pclk);
    endtask
endmodule

// ---- verif/eq_serial_checker.sv ----
`timescale 1ns/1ps
module eq_serial_checker
    import eq_ctrl_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic latch_pulse_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [NUM_BANDS*SW_PER_BAND-1:0] band_switches,
    input wire logic range_a_narrow,
    input wire logic range_b_narrow
);
    logic [3:0] since_q;
    // cycles since latch release, saturating so it never wraps
    always_ff @(posedge pclk or negedge presetn)
        if (!presetn)
            since_q <= 4'hf;
        else if (!latch_pulse_n)
            since_q <= 4'h0;
        else if (since_q != 4'hf)
            since_q <= since_q + 4'h1;
    default clocking @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    sequence access_s;
        psel && penable;
    endsequence
    sw_hold_a: assert property (
        $changed(band_switches) |-> since_q <= 4'h8)
        else $error("switches moved without latch");
    range_hold_a: assert property (
        $changed({range_a_narrow, range_b_narrow}) |-> since_q <= 4'h8)
        else $error("range moved without latch");
    dir_low_a: assert property (
        !(|band_switches[5:0] && |band_switches[11:6]))
        else $error("band 1 boost and cut");
    dir_high_a: assert property (
        !(|band_switches[161:156] && |band_switches[167:162]))
        else $error("band 14 boost and cut");
    ready_a: assert property (access_s |-> pready)
        else $error("no ready");
    write_err_a: assert property (access_s and pwrite |-> pslverr)
        else $error("write accepted");
    unmapped_err_a: assert property (
        access_s and paddr == 12'hffc |-> pslverr)
        else $error("unmapped accepted");
    read_ok_a: assert property (
        access_s and !pwrite && paddr == OFS_BAND |-> !pslverr)
        else $error("band read refused");
endmodule
bind equalizer_serial_control eq_serial_checker i_eq_serial_checker (
    .pclk(pclk), .presetn(presetn), .latch_pulse_n(latch_pulse_n),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pready(pready), .pslverr(pslverr), .band_switches(band_switches),
    .range_a_narrow(range_a_narrow), .range_b_narrow(range_b_narrow));

// ---- verif/test_equalizer_serial_control.sv ----
`timescale 1ns/1ps
module test_equalizer_serial_control;
    import eq_ctrl_pkg::*;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] wdat = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [NUM_BANDS*SW_PER_BAND-1:0] sw;
    logic ra;
    logic rb;
    logic sclk;
    logic sdat;
    logic lat_n;
    logic [31:0] rd;
    logic err;
    int mismatches = 0;
    int n_checks = 0;
    int cyc = 0;
    logic [5:0] codes [12] = '{6'h20, 6'h10, 6'h08, 6'h04, 6'h02, 6'h12,
        6'h2a, 6'h16, 6'h01, 6'h29, 6'h2d, 6'h2f};
    equalizer_serial_control i_equalizer_serial_control (.pclk(pclk),
        .presetn(presetn), .serial_clk(sclk), .serial_data(sdat),
        .latch_pulse_n(lat_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(wdat), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .band_switches(sw),
        .range_a_narrow(ra), .range_b_narrow(rb));
    eq_word_gen i_eq_word_gen (.pclk(pclk), .serial_clk(sclk),
        .serial_data(sdat), .latch_pulse_n(lat_n));
    always #10 pclk = ~pclk;
    // hang guard, well above the ~1400 cycles the run needs
    always @(posedge pclk)
    begin
        cyc <= cyc + 1;
        if (cyc == 5000)
        begin
            mismatches++;
            conclude();
        end
    end
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        wdat <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1)
            @(posedge pclk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk); // idle cycle keeps back-to-back calls apart
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        n_checks++;
        if (g !== e)
        begin
            mismatches++;
            $display("BAD %0t got %h want %h", $time, g, e);
        end
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    initial
    begin
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(1'b0, OFS_BAND, 32'h0);
        chk(rd, {24'h0, BAND_RST});
        chk({31'h0, |sw}, 32'h0);
        i_eq_word_gen.send(8'h81);
        i_eq_word_gen.send(8'h60);
        chk(sw[11:0], 12'h020);
        i_eq_word_gen.send(8'h2f);
        chk(sw[11:0], 12'hbc0);
        i_eq_word_gen.send(8'h00);
        chk(sw[11:0], 12'h000);
        i_eq_word_gen.send(8'hbe);
        chk({ra, rb}, 2'b11);
        // every step as boost on band 14, band word sent once
        foreach (codes[i])
        begin
            i_eq_word_gen.send({2'b01, codes[i]});
            chk(sw[13*12 +: 12], {6'h00, codes[i]});
        end
        apb(1'b0, OFS_SHIFT, 32'h0);
        chk(rd, 32'h6f);
        apb(1'b0, OFS_GAIN_BASE + 12'h034, 32'h0);
        chk(rd, 32'h6f);
        apb(1'b0, 12'hffc, 32'h0);
        chk(err, 1'b1);
        apb(1'b1, OFS_BAND, 32'h0000_00ff);
        chk(err, 1'b1);
        apb(1'b0, OFS_BAND, 32'h0);
        chk(rd, 32'hbe);
        conclude();
    end
endmodule
